//--- hdl/nmc_pkg.sv
// Purpose: shared constants for the navigation monitor alarm comparator
// Assumes: pclk at 125 MHz, APB register access
// Notes: byte offsets, field positions, reset values and timing counts
package nmc_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SAMPLE_HZ = 640;
  localparam int unsigned N_SLOTS = 27;
  localparam int unsigned SLOT_CYC_DEF = CLK_HZ / (SAMPLE_HZ * N_SLOTS);
  localparam int unsigned BEAT_SCALE = 20;
  localparam int unsigned GATE_CYC_DEF = CLK_HZ / BEAT_SCALE;
  localparam int unsigned CONV_NS = 200;
  localparam int unsigned CONV_CYC = CONV_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned READY_NS = 1000;
  localparam int unsigned READY_CYC = READY_NS * (CLK_HZ / 1_000_000) / 1000;
  // ----------------------------------------
  // widths and depths
  // ----------------------------------------
  localparam int DW = 12;
  localparam int CHW = 5;
  localparam int ACQ_W = 17;
  localparam int ACQ_DEPTH = 7;
  localparam int N_PARAM = 32;
  localparam int OUT_DEPTH = 32;
  localparam int EE_AW = 7;
  localparam int EE_W = 18;
  // ----------------------------------------
  // acquisition slots, in visiting order
  // ----------------------------------------
  localparam logic [4:0] SLOT_BEAT = 5'h00;
  localparam logic [4:0] SLOT_ADC0 = 5'h01;
  localparam logic [4:0] SLOT_EXT0 = 5'h11;
  localparam logic [4:0] SLOT_DCL = 5'h19;
  localparam logic [4:0] SLOT_TEST = 5'h1a;
  localparam logic [11:0] TEST_RST = 12'haaa;
  // ----------------------------------------
  // limit store word kinds, address = {param, kind}
  // ----------------------------------------
  localparam logic [1:0] K_UP = 2'h0;
  localparam logic [1:0] K_LO = 2'h1;
  localparam logic [1:0] K_DLY = 2'h2;
  localparam logic [1:0] K_WARN = 2'h3;
  // check-bit column of each data bit, bit 0 in the low five bits
  localparam logic [59:0] EE_COLS = {5'h11, 5'h0f, 5'h0e, 5'h0d, 5'h0c,
    5'h0b, 5'h0a, 5'h09, 5'h07, 5'h06, 5'h05, 5'h03};
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACQ = 8'h08;
  localparam logic [7:0] OFF_PARAM = 8'h0c;
  localparam logic [7:0] OFF_EE_ADDR = 8'h10;
  localparam logic [7:0] OFF_EE_DATA = 8'h14;
  localparam logic [7:0] OFF_OUT = 8'h18;
  localparam logic [7:0] OFF_BEAT = 8'h1c;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CTRL_ACQ_EN = 0;
  localparam int CTRL_STBY = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int ST_OVF = 1;
  localparam int ST_PWARN = 2;
  localparam int ST_PERR = 3;
  localparam int ST_SEQ = 4;
  localparam int ST_BLOCK = 5;
  localparam int PARAM_ID_LSB = 16;
  localparam int INJ_LSB = 12;
endpackage : nmc_pkg

//--- hdl/nmc_acq_fifo.sv
// Purpose: seven-entry acquisition queue between sequencer and processor
// Assumes: single clock, push and pop in the same cycle allowed
// Notes: a push while full is dropped and flagged as overflow
`timescale 1ns/10ps
module nmc_acq_fifo (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic wr_valid,
  input wire logic [nmc_pkg::ACQ_W-1:0] wr_data,
  output logic wr_ready,
  output logic overflow,
  // read side
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [nmc_pkg::ACQ_W-1:0] rd_data
);
  import nmc_pkg::*;
  logic [ACQ_W-1:0] mem [ACQ_DEPTH];
  logic [2:0] wp_reg;
  logic [2:0] rp_reg;
  logic [3:0] cnt_reg;
  wire push = wr_valid && wr_ready;
  wire pop = rd_ready && rd_valid;
  wire [2:0] wp_inc = (wp_reg == 3'(ACQ_DEPTH - 1)) ? 3'h0 : wp_reg + 3'h1;
  wire [2:0] rp_inc = (rp_reg == 3'(ACQ_DEPTH - 1)) ? 3'h0 : rp_reg + 3'h1;
  assign wr_ready = cnt_reg != 4'(ACQ_DEPTH);
  assign rd_valid = cnt_reg != 4'h0;
  assign rd_data = mem[rp_reg];
  assign overflow = wr_valid && !wr_ready;
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_reg] <= wr_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= 3'h0;
      rp_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end else begin
      wp_reg <= push ? wp_inc : wp_reg;
      rp_reg <= pop ? rp_inc : rp_reg;
      cnt_reg <= cnt_reg + 4'(push) - 4'(pop);
    end
  end
endmodule : nmc_acq_fifo

//--- hdl/nmc_top.sv
// Purpose: monitor acquisition front end, limit comparator and alarm buses
// Assumes: APB master on pclk, limit store loaded by software first
// Notes: parameter values arrive through the PARAM register
// Overview of operation
// - divide the clock into channel slots and pulse the ADC convert
// - count beat pulses in a window so count times twenty is hertz
// - visit beat value, sixteen ADC and eight external channels in turn
// - stream also carries dc loop detect, external value, test entries
// - every channel is sampled at 640 Hz by the slot sequence
// - acquisition queue holds seven 17-bit words: address and sample
// - queue shows entry-available flag and reports errors onward
// - latch parameter number and value as delivered
// - read upper, lower limits, compare, then read delay and apply
// - raw alarm when value lies above upper or below lower limit
// - instantaneous alarm plus delayed alarm after programmed persistence
// - single-bit store error corrected with warning; double forces alarms
// - limit store writes only while access level input is low
// - store holds alarm limits, delays and host warning limits
// - finished comparison writes value and alarm data to output queue
// - host interrupt only after all thirty-two parameters are queued
// - host side controls interrupt and limit store programming
// - station-control bus: id, ready strobe, alarm, inverse, raw
// - terminator bus has the same five parts
// - standby bus carries only ready strobe and alarm
`timescale 1ns/10ps
module nmc_top #(
  parameter int unsigned SLOT_CYC = nmc_pkg::SLOT_CYC_DEF,
  parameter int unsigned GATE_CYC = nmc_pkg::GATE_CYC_DEF
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // acquisition pins
  input wire logic beat_frequency,
  input wire logic [nmc_pkg::DW-1:0] adc_data,
  input wire logic [nmc_pkg::DW-1:0] ext_val,
  input wire logic [3:0] dc_loop_detect,
  output logic adc_convert,
  output logic [3:0] adc_sel,
  output logic [2:0] ext_sel,
  output logic fifo_has_entry,
  // maintenance side
  input wire logic access_level_bit,
  output logic data_ready_irq,
  // station-control alarm bus
  output logic [4:0] sc_param_id,
  output logic sc_ready_n,
  output logic sc_alarm,
  output logic sc_alarm_inverted_n,
  output logic sc_alarm_unfiltered,
  // terminator alarm bus
  output logic [4:0] term_param_id,
  output logic term_ready_n,
  output logic term_alarm,
  output logic term_alarm_inverted_n,
  output logic term_alarm_unfiltered,
  // standby alarm bus
  output logic standby_ready_n,
  output logic standby_alarm
);
  import nmc_pkg::*;

  // ----------
  // limit store check code
  // ----------
  function automatic logic [5:0] ee_chk(input logic [DW-1:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int j = 0; j < DW; j++) begin
      if (d[j]) c = c ^ EE_COLS[j*5 +: 5];
    end
    return {^{d, c}, c};
  endfunction : ee_chk

  // returns {double error, single error, corrected data}
  function automatic logic [13:0] ee_dec(input logic [EE_W-1:0] w);
    logic [5:0] ck;
    logic [4:0] syn;
    logic ov;
    logic [DW-1:0] d;
    ck = ee_chk(w[DW-1:0]);
    syn = ck[4:0] ^ w[16:12];
    ov = ^w;
    d = w[DW-1:0];
    for (int j = 0; j < DW; j++) begin
      if (ov && syn == EE_COLS[j*5 +: 5]) d[j] = !d[j];
    end
    return {!ov && syn != 5'h00, ov, d};
  endfunction : ee_dec

  // ----------
  // pin synchronisers
  // ----------
  logic [29:0] s1_reg, s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 30'h0;
      s2_reg <= 30'h0;
    end else begin
      s1_reg <= {beat_frequency, adc_data, ext_val, dc_loop_detect,
                 access_level_bit};
      s2_reg <= s1_reg;
    end
  end
  wire beat_s = s2_reg[29];
  wire [DW-1:0] adc_s = s2_reg[28:17];
  wire [DW-1:0] ext_s = s2_reg[16:5];
  wire [3:0] dcl_s = s2_reg[4:1];
  wire acl_s = s2_reg[0];

  // ----------
  // slot sequencer and convert pulse
  // ----------
  logic [12:0] slot_cnt_reg;
  logic [4:0] slot_reg;
  logic [1:0] ctrl_reg;
  logic [DW-1:0] test_reg, beat_val_reg, sample;
  wire acq_en = ctrl_reg[CTRL_ACQ_EN];
  wire slot_end = slot_cnt_reg == 13'(SLOT_CYC - 1);
  wire [12:0] slot_cnt_next = slot_end ? 13'h0 : slot_cnt_reg + 13'h1;
  wire [4:0] slot_next = !slot_end ? slot_reg :
    (slot_reg == 5'(N_SLOTS - 1)) ? 5'h0 : slot_reg + 5'h1;
  wire adc_slot_n = slot_next >= SLOT_ADC0 && slot_next < SLOT_EXT0;
  wire is_adc = slot_reg >= SLOT_ADC0 && slot_reg < SLOT_EXT0;
  wire is_ext = slot_reg >= SLOT_EXT0 && slot_reg < SLOT_DCL;
  always_comb begin
    sample = test_reg;
    if (slot_reg == SLOT_BEAT) sample = beat_val_reg;
    else if (is_adc) sample = adc_s;
    else if (is_ext) sample = ext_s;
    else if (slot_reg == SLOT_DCL) sample = {8'h00, dcl_s};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt_reg <= 13'h0;
      slot_reg <= 5'h0;
      adc_convert <= 1'b0;
      adc_sel <= 4'h0;
      ext_sel <= 3'h0;
      test_reg <= TEST_RST;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
      slot_reg <= slot_next;
      // a started pulse runs to full length even if acq_en drops
      adc_convert <= adc_slot_n && slot_cnt_next < 13'(CONV_CYC) &&
        (acq_en || (adc_convert && slot_cnt_next != 13'h0));
      adc_sel <= 4'(slot_next - SLOT_ADC0);
      ext_sel <= 3'(slot_next - SLOT_EXT0);
      if (slot_end && slot_reg == SLOT_TEST) test_reg <= ~test_reg;
    end
  end

  // ----------
  // beat frequency counter
  // ----------
  logic [23:0] gate_reg;
  logic [DW-1:0] beat_cnt_reg;
  logic beat_prev_reg;
  wire gate_end = gate_reg == 24'(GATE_CYC - 1);
  wire beat_rise = beat_s && !beat_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= 24'h0;
      beat_cnt_reg <= 12'h000;
      beat_val_reg <= 12'h000;
      beat_prev_reg <= 1'b0;
    end else begin
      beat_prev_reg <= beat_s;
      gate_reg <= gate_end ? 24'h0 : gate_reg + 24'h1;
      if (gate_end) begin
        beat_val_reg <= beat_cnt_reg;
        beat_cnt_reg <= 12'(beat_rise);
      end else if (beat_rise && beat_cnt_reg != 12'hfff) begin
        beat_cnt_reg <= beat_cnt_reg + 12'h001;
      end
    end
  end

  // ----------
  // apb decode
  // ----------
  logic [EE_AW-1:0] ee_addr_reg;
  logic [EE_W-1:0] ee_mem [2**EE_AW];
  logic acq_valid, acq_ovf_pulse;
  logic [ACQ_W-1:0] acq_data;
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite;
  wire rd_acc = acc && !pwrite;
  wire setup = psel && !penable;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_st = paddr == OFF_STATUS;
  wire hit_acq = paddr == OFF_ACQ;
  wire hit_par = paddr == OFF_PARAM;
  wire hit_eea = paddr == OFF_EE_ADDR;
  wire hit_eed = paddr == OFF_EE_DATA;
  wire hit_out = paddr == OFF_OUT;
  wire hit_beat = paddr == OFF_BEAT;
  wire mapped = hit_ctrl | hit_st | hit_acq | hit_par | hit_eea | hit_eed |
    hit_out | hit_beat;
  wire ee_wr = wr_acc && hit_eed && !acl_s;
  wire ee_blocked = wr_acc && hit_eed && acl_s;
  wire [DW-1:0] ee_wd = pwdata[DW-1:0];
  // injection mask lets software exercise the error paths
  wire [EE_W-1:0] ee_word = {ee_chk(ee_wd), ee_wd} ^ pwdata[29:12];

  // ----------
  // acquisition queue
  // ----------
  nmc_acq_fifo u_acq (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(slot_end && acq_en),
    .wr_data({slot_reg, sample}),
    .wr_ready(),
    .overflow(acq_ovf_pulse),
    .rd_ready(rd_acc && hit_acq),
    .rd_valid(acq_valid),
    .rd_data(acq_data)
  );

  always_ff @(posedge pclk) begin
    if (ee_wr) ee_mem[ee_addr_reg] <= ee_word;
  end

  // ----------
  // comparator sequence
  // ----------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_UP = 6'b000010,
    S_LO = 6'b000100,
    S_DLY = 6'b001000,
    S_OUT = 6'b010000,
    S_STRB = 6'b100000
  } nmc_state_t;
  nmc_state_t st_reg, st_next;
  logic [4:0] id_reg, next_id_reg;
  logic [DW-1:0] val_reg, up_reg;
  logic raw_reg, alarm_reg, cyc_pw_reg, cyc_pe_reg;
  logic [DW-1:0] cnt_mem [N_PARAM];
  logic [7:0] strb_reg;
  logic [5:0] out_cnt_reg;
  wire idle = st_reg == S_IDLE;
  wire par_wr = wr_acc && hit_par;
  wire [4:0] par_id = pwdata[PARAM_ID_LSB +: 5];
  wire par_take = par_wr && idle && par_id == next_id_reg;
  wire [1:0] kind = (st_reg == S_UP) ? K_UP : (st_reg == S_LO) ? K_LO : K_DLY;
  wire [13:0] dec = ee_dec(ee_mem[{id_reg, kind}]);
  wire [DW-1:0] ee_d = dec[DW-1:0];
  wire reading = st_reg == S_UP || st_reg == S_LO || st_reg == S_DLY;
  wire pw_ev = reading && dec[12];
  wire pe_ev = reading && dec[13];
  wire [DW-1:0] cnt_cur = cnt_mem[id_reg];
  wire out_push = st_reg == S_OUT && out_cnt_reg != 6'(OUT_DEPTH);
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      S_IDLE: if (par_take) st_next = S_UP;
      S_UP: st_next = S_LO;
      S_LO: st_next = S_DLY;
      S_DLY: st_next = S_OUT;
      S_OUT: if (out_push) st_next = S_STRB; // stalls on a full queue
      S_STRB: if (strb_reg == 8'h00) st_next = S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      id_reg <= 5'h0;
      next_id_reg <= 5'h0;
      val_reg <= 12'h000;
      up_reg <= 12'h000;
      raw_reg <= 1'b0;
      alarm_reg <= 1'b0;
      cyc_pw_reg <= 1'b0;
      cyc_pe_reg <= 1'b0;
      strb_reg <= 8'h00;
      for (int i = 0; i < N_PARAM; i++) cnt_mem[i] <= 12'h000;
    end else begin
      st_reg <= st_next;
      if (par_take) begin
        id_reg <= par_id;
        val_reg <= pwdata[DW-1:0];
        cyc_pw_reg <= 1'b0;
        cyc_pe_reg <= 1'b0;
      end else begin
        cyc_pw_reg <= cyc_pw_reg | pw_ev;
        cyc_pe_reg <= cyc_pe_reg | pe_ev;
      end
      if (st_reg == S_UP) up_reg <= ee_d;
      if (st_reg == S_LO) begin
        raw_reg <= val_reg > up_reg || val_reg < ee_d;
      end
      if (st_reg == S_DLY) begin
        alarm_reg <= raw_reg && cnt_cur >= ee_d;
        cnt_mem[id_reg] <= !raw_reg ? 12'h000 :
          (cnt_cur == 12'hfff) ? cnt_cur : cnt_cur + 12'h001;
      end
      if (out_push) strb_reg <= 8'(READY_CYC - 1);
      else if (strb_reg != 8'h00) strb_reg <= strb_reg - 8'h01;
      if (st_reg == S_STRB && strb_reg == 8'h00) begin
        next_id_reg <= next_id_reg + 5'h1;
      end
    end
  end

  // ----------
  // status flags, set wins over clear
  // ----------
  logic ovf_reg, pwarn_reg, perr_reg, seq_reg, blk_reg;
  wire st_w = wr_acc && hit_st;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
      pwarn_reg <= 1'b0;
      perr_reg <= 1'b0;
      seq_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      ovf_reg <= acq_ovf_pulse || (ovf_reg && !(st_w && pwdata[ST_OVF]));
      pwarn_reg <= pw_ev || (pwarn_reg && !(st_w && pwdata[ST_PWARN]));
      perr_reg <= pe_ev || (perr_reg && !(st_w && pwdata[ST_PERR]));
      seq_reg <= (par_wr && !par_take) || (seq_reg && !(st_w && pwdata[ST_SEQ]));
      blk_reg <= ee_blocked || (blk_reg && !(st_w && pwdata[ST_BLOCK]));
    end
  end

  // ----------
  // output queue toward the maintenance host
  // ----------
  logic [31:0] out_mem [OUT_DEPTH];
  logic [4:0] owp_reg, orp_reg;
  wire out_pop = rd_acc && hit_out && out_cnt_reg != 6'h00;
  wire force_al = perr_reg || cyc_pe_reg;
  wire al_f = alarm_reg || force_al;
  wire raw_f = raw_reg || force_al;
  always_ff @(posedge pclk) begin
    if (out_push) begin
      out_mem[owp_reg] <= {cyc_pe_reg, cyc_pw_reg, ovf_reg, raw_f, al_f,
        6'h00, id_reg, 4'h0, val_reg};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owp_reg <= 5'h0;
      orp_reg <= 5'h0;
      out_cnt_reg <= 6'h00;
      data_ready_irq <= 1'b0;
    end else begin
      owp_reg <= owp_reg + 5'(out_push);
      orp_reg <= orp_reg + 5'(out_pop);
      out_cnt_reg <= out_cnt_reg + 6'(out_push) - 6'(out_pop);
      data_ready_irq <= (out_push && id_reg == 5'(N_PARAM - 1)) ||
        (data_ready_irq && !(out_pop && out_cnt_reg == 6'h01));
    end
  end

  // ----------
  // alarm buses
  // ----------
  wire stby = ctrl_reg[CTRL_STBY];
  wire strobing = st_reg == S_STRB && strb_reg != 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_param_id <= 5'h0;
      sc_ready_n <= 1'b1;
      sc_alarm <= 1'b0;
      sc_alarm_inverted_n <= 1'b1;
      sc_alarm_unfiltered <= 1'b0;
      term_param_id <= 5'h0;
      term_ready_n <= 1'b1;
      term_alarm <= 1'b0;
      term_alarm_inverted_n <= 1'b1;
      term_alarm_unfiltered <= 1'b0;
      standby_ready_n <= 1'b1;
      standby_alarm <= 1'b0;
    end else begin
      if (out_push) begin
        sc_param_id <= id_reg;
        sc_alarm <= al_f;
        sc_alarm_inverted_n <= !al_f;
        sc_alarm_unfiltered <= raw_f;
        term_param_id <= id_reg;
        term_alarm <= al_f;
        term_alarm_inverted_n <= !al_f;
        term_alarm_unfiltered <= raw_f;
        standby_alarm <= stby && al_f;
      end
      sc_ready_n <= !out_push && !strobing;
      term_ready_n <= !out_push && !strobing;
      standby_ready_n <= !(stby && (out_push || strobing));
    end
  end

  // ----------
  // apb registers and read data
  // ----------
  logic [31:0] rd_mux;
  wire [31:0] st_word = {21'h0, out_cnt_reg == 6'h00, 1'b0,
    !idle, acl_s, data_ready_irq, blk_reg, seq_reg, perr_reg, pwarn_reg,
    ovf_reg, acq_valid};
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) rd_mux = {30'h0, ctrl_reg};
    if (hit_st) rd_mux = st_word;
    if (hit_acq) rd_mux = {acq_valid, 14'h0, acq_data};
    if (hit_par) rd_mux = {11'h0, next_id_reg, 16'h0};
    if (hit_eea) rd_mux = {25'h0, ee_addr_reg};
    if (hit_eed) rd_mux = {14'h0, ee_mem[ee_addr_reg]};
    if (hit_out) rd_mux = out_mem[orp_reg];
    if (hit_beat) rd_mux = {20'h0, beat_val_reg};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_reg <= CTRL_RST;
      ee_addr_reg <= 7'h0;
      fifo_has_entry <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) prdata <= mapped ? rd_mux : 32'h0;
      if (wr_acc && hit_ctrl) ctrl_reg <= pwdata[1:0];
      if (wr_acc && hit_eea) ee_addr_reg <= pwdata[EE_AW-1:0];
      fifo_has_entry <= acq_valid;
    end
  end
endmodule : nmc_top

//--- tb/nmc_top_asserts.sv
// Purpose: port checks on nmc_top
// Assumes: one clock, async active-low reset
// Notes: bound after the module
`timescale 1ns/10ps
module nmc_top_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // pins
  input wire logic adc_convert,
  input wire logic data_ready_irq,
  // alarm buses
  input wire logic [4:0] sc_param_id,
  input wire logic sc_ready_n,
  input wire logic sc_alarm,
  input wire logic sc_alarm_inverted_n,
  input wire logic [4:0] term_param_id,
  input wire logic term_ready_n,
  input wire logic term_alarm,
  input wire logic standby_ready_n,
  input wire logic standby_alarm
);
  // ----
  // strobe tracking
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] nid_reg;
  logic rdy_reg;
  wire strobe = rdy_reg && !sc_ready_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nid_reg <= 5'h00;
      rdy_reg <= 1'b1;
    end else begin
      rdy_reg <= sc_ready_n;
      if (strobe) nid_reg <= nid_reg + 5'h01;
    end
  end
  a_apb_access: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("bad pready");
  a_inv_pair: assert property (
    sc_alarm_inverted_n == !sc_alarm) else $error("inverse wrong");
  a_term_copy: assert property (
    term_param_id == sc_param_id && term_ready_n == sc_ready_n &&
    term_alarm == sc_alarm) else $error("term bus differs");
  a_stby_bus: assert property (
    !standby_ready_n |-> !sc_ready_n && standby_alarm == sc_alarm)
    else $error("standby bus wrong");
  a_strobe_len: assert property (
    strobe |-> ##124 !sc_ready_n ##1 sc_ready_n) else $error("strobe len");
  a_id_order: assert property (
    strobe |-> sc_param_id == nid_reg) else $error("id out of order");
  a_irq_set: assert property (
    $rose(data_ready_irq) |-> strobe && sc_param_id == 5'h1f)
    else $error("early irq");
  a_conv_len: assert property (
    $rose(adc_convert) |-> ##24 adc_convert ##1 !adc_convert)
    else $error("convert len");
endmodule : nmc_top_asserts
bind nmc_top nmc_top_asserts u_nmc_top_asserts (.pclk, .presetn, .psel,
  .penable, .pready, .adc_convert, .data_ready_irq, .sc_param_id,
  .sc_ready_n, .sc_alarm, .sc_alarm_inverted_n, .term_param_id,
  .term_ready_n, .term_alarm, .standby_ready_n, .standby_alarm);

//--- tb/nmc_alarm_rx.sv
// Purpose: receiving alarm logic on the station-control bus
// Assumes: one strobe per parameter
// Notes: no strobe timeout, the bench idles too long between sets
`timescale 1ns/10ps
module nmc_alarm_rx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // alarm bus
  input wire logic [4:0] param_id,
  input wire logic ready_n,
  input wire logic alarm,
  input wire logic alarm_inverted_n,
  // verdict
  output logic mon_alarm,
  output logic [7:0] n_bad
);
  // ----
  // checks per strobe
  // ----
  logic rdy_reg;
  logic [4:0] id_reg;
  logic [5:0] clean_reg;
  wire take = rdy_reg && !ready_n;
  wire bad = param_id != id_reg || alarm_inverted_n == alarm;
  wire hit = alarm || bad;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_reg <= 1'b1;
      id_reg <= 5'h00;
      clean_reg <= 6'h00;
      mon_alarm <= 1'b0;
      n_bad <= 8'h00;
    end else begin
      rdy_reg <= ready_n;
      if (take) begin
        id_reg <= param_id + 5'h01;
        n_bad <= n_bad + {7'h00, bad};
        clean_reg <= hit ? 6'h00 : clean_reg + 6'h01;
        mon_alarm <= hit || (mon_alarm && clean_reg != 6'h1f);
      end
    end
  end
endmodule : nmc_alarm_rx

//--- tb/tb_top.sv
// Purpose: self-checking bench for nmc_top
// Assumes: short slot and gate counts
// Notes: partner model watches the station-control bus
`timescale 1ns/10ps
module tb_top;
  import nmc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, beat = 1'b0, lvl = 1'b0, re, rx_alarm;
  logic [7:0] paddr = 8'h00, rx_bad;
  logic [31:0] pwdata = 32'h0, rv;
  logic [3:0] bc = 4'h0;
  logic [31:0] prdata;
  logic [4:0] sc_param_id;
  logic pready, pslverr, fifo_has_entry, irq, sc_ready_n, sc_alarm;
  logic sc_alarm_inverted_n, sc_alarm_unfiltered;
  int n_errors = 0, n_checks = 0;
  // ----
  // design, partner, stimulus
  // ----
  nmc_top #(.SLOT_CYC(40), .GATE_CYC(200)) u_nmc_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .beat_frequency(beat), .adc_data(12'h123), .ext_val(12'h456),
    .dc_loop_detect(4'h5), .adc_convert(), .adc_sel(), .ext_sel(),
    .fifo_has_entry, .access_level_bit(lvl), .data_ready_irq(irq),
    .sc_param_id, .sc_ready_n, .sc_alarm, .sc_alarm_inverted_n,
    .sc_alarm_unfiltered, .term_param_id(), .term_ready_n(), .term_alarm(),
    .term_alarm_inverted_n(), .term_alarm_unfiltered(), .standby_ready_n(),
    .standby_alarm());
  nmc_alarm_rx u_nmc_alarm_rx (.pclk, .presetn, .param_id(sc_param_id),
    .ready_n(sc_ready_n), .alarm(sc_alarm),
    .alarm_inverted_n(sc_alarm_inverted_n), .mon_alarm(rx_alarm),
    .n_bad(rx_bad));
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    bc <= (bc == 4'h9) ? 4'h0 : bc + 4'h1;
    beat <= bc < 4'h5;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ee(input logic [6:0] a, input logic [31:0] d);
    apb(1'b1, OFF_EE_ADDR, {25'h0, a});
    apb(1'b1, OFF_EE_DATA, d);
  endtask : ee
  task automatic t_bus;
    apb(1'b0, 8'h40, 32'h0);
    chk({re, rv[30:0]}, 32'h80000000);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rv, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h3);
    $display("t_bus done");
  endtask : t_bus
  task automatic t_load;
    for (int p = 0; p < 32; p++) begin
      ee({p[4:0], K_UP}, 32'h800);
      ee({p[4:0], K_LO}, 32'h100);
      ee({p[4:0], K_DLY}, (p == 1) ? 32'h1 : 32'h0);
      ee({p[4:0], K_WARN}, 32'h0);
    end
    lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    ee({5'h1f, K_UP}, 32'h123);
    apb(1'b0, OFF_EE_DATA, 32'h0);
    chk(rv & 32'hfff, 32'h800);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rv & 32'h20, 32'h20);
    lvl <= 1'b0;
    $display("t_load done");
  endtask : t_load
  task automatic t_acq;
    logic [4:0] s, q;
    logic [11:0] e;
    apb(1'b0, OFF_BEAT, 32'h0);
    chk(rv[11:0] >= 12'd19 && rv[11:0] <= 12'd21, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({rv[1], fifo_has_entry}, 32'h3);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, OFF_ACQ, 32'h0);
      s = rv[16:12];
      e = (s < SLOT_EXT0) ? 12'h123 : (s < SLOT_DCL) ? 12'h456 : 12'h005;
      if (s == SLOT_BEAT || s == SLOT_TEST) e = rv[11:0];
      chk(rv[31], i < 7);
      if (i < 7) chk(rv[11:0], e);
      if (i > 0 && i < 7) chk(s, (q == 5'd26) ? 5'd0 : q + 5'd1);
      q = s;
    end
    chk(fifo_has_entry, 32'h0);
    $display("t_acq done");
  endtask : t_acq
  task automatic t_round(input int r);
    logic ra, al;
    logic [11:0] v;
    for (int p = 0; p < 32; p++) begin
      ra = (p >= 1 && p <= 4) || (r == 1 && p >= 5);
      al = (p >= 2 && p <= 4) || (r == 1 && p >= 1);
      v = (p == 3) ? 12'h050 : (p == 4) ? 12'h801 : (p < 3) ? 12'h900 : 12'h400;
      if (p == 0) v = 12'h400;
      apb(1'b1, OFF_PARAM, {11'h0, p[4:0], 4'h0, v});
      repeat (5) @(posedge pclk);
      #1;
      chk({sc_ready_n, sc_param_id, sc_alarm_unfiltered, sc_alarm},
        {1'b0, p[4:0], ra, al});
      chk(irq, (p == 31) ? 32'h1 : 32'h0);
      apb(1'b0, OFF_OUT, 32'h0);
      chk(rv & 32'h181f0fff, {3'h0, ra, al, 6'h0, p[4:0], 4'h0, v});
      do apb(1'b0, OFF_STATUS, 32'h0); while (rv[8] !== 1'b0);
    end
    $display("t_round done");
  endtask : t_round
  task automatic t_fault;
    ee({5'h04, K_UP}, 32'h1800);
    ee({5'h05, K_UP}, 32'h3800);
    t_round(1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rv & 32'hc, 32'hc);
    chk({rx_bad, 7'h0, rx_alarm}, 32'h1);
    apb(1'b1, OFF_STATUS, 32'h3e);
    apb(1'b1, OFF_PARAM, 32'h50400);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({sc_ready_n, rv[4]}, 32'h3);
    $display("t_fault done");
  endtask : t_fault
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_load();
    t_acq();
    t_round(0);
    t_fault();
    conclude();
  end
endmodule : tb_top
